// >>> srom_defs.vh
// Constants of the serial configuration memory access block.
// Assumes inclusion by the block's design files only; holds definitions alone.
`ifndef SROM_DEFS_VH
`define SROM_DEFS_VH

// Register byte offsets on the AHB-Lite window, low twelve address bits.
`define SROM_CTRL_OFS      12'h0a0
`define SROM_ADDR_OFS      12'h0a4
`define SROM_ISTAT_OFS     12'h0c0
`define SROM_IMASK_OFS     12'h0c4

// Control register field positions.
`define SROM_GO_BIT        0
`define SROM_OP_LO         1
`define SROM_OP_HI         3
`define SROM_PLDONE_BIT    4
`define SROM_PLDIS_BIT     5
`define SROM_RATE_LO       6
`define SROM_RATE_HI       7
`define SROM_STAT_LO       8
`define SROM_STAT_HI       15

// Software opcodes held in the opcode field.
`define SROM_OP_NONE       3'h0
`define SROM_OP_WRSR       3'h1
`define SROM_OP_WRITE      3'h2
`define SROM_OP_READ       3'h3
`define SROM_OP_WRDI       3'h4
`define SROM_OP_RDSR       3'h5
`define SROM_OP_WREN       3'h6

// Instruction bytes sent to the memory for each opcode.
`define SROM_INS_WRSR      8'h01
`define SROM_INS_WRITE     8'h02
`define SROM_INS_READ      8'h03
`define SROM_INS_WRDI      8'h04
`define SROM_INS_RDSR      8'h05
`define SROM_INS_WREN      8'h06

// Bits shifted per access kind.
`define SROM_BITS_SHORT    6'd8
`define SROM_BITS_STAT     6'd16
`define SROM_BITS_DATA     6'd40

// Reset values and the test rate code.
`define SROM_PLDIS_RST     1'b1
`define SROM_RATE_RST      2'h1
`define SROM_RATE_TEST     2'h3

// Serial clock: core clock of 250 MHz divided by 64, or by 2 in test, split in half periods.
`define SROM_CORE_MHZ      250
`define SROM_DIV           64
`define SROM_HALF_DIV      6'd32
`define SROM_HALF_TEST     6'd1

// Interrupt status bit positions.
`define SROM_IRQ_DONE      0
`define SROM_IRQ_PRELOAD   1

`endif

// >>> srom_shift.v
// Serial engine: clock divider and shift register for the memory pins.
// Assumes a start pulse only while idle and a miso already synchronised.
`timescale 1ns/1ns
`include "srom_defs.vh"

module srom_shift (
	// Clock and reset.
	input  wire        hclk,
	input  wire        hresetn,
	// Request and answer.
	input  wire        start,
	input  wire [5:0]  nbits,
	input  wire [39:0] tx,
	input  wire [5:0]  half,
	output reg         busy_r,
	output reg         done_r,
	output reg  [15:0] rx_r,
	// Memory pins.
	input  wire        miso,
	output reg         sclk_r,
	output reg         cs_n_r,
	output reg         mosi_r
);

	reg [39:0] sh_r;
	reg [5:0]  cnt_r;
	reg [5:0]  div_r;

	// Mode 0 framing: data set up on the falling edge, sampled on the rising.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
			rx_r   <= 16'h0000;
			sclk_r <= 1'b0;
			cs_n_r <= 1'b1;
			mosi_r <= 1'b0;
			sh_r   <= 40'h0000000000;
			cnt_r  <= 6'h00;
			div_r  <= 6'h00;
		end else begin
			done_r <= 1'b0;
			if (!busy_r) begin
				if (start) begin
					busy_r <= 1'b1;
					cs_n_r <= 1'b0;
					sh_r   <= tx;
					mosi_r <= tx[39];
					cnt_r  <= nbits;
					div_r  <= 6'h00;
				end
			end else if (div_r == half - 6'd1) begin
				div_r <= 6'h00;
				if (!sclk_r) begin
					sclk_r <= 1'b1;
					rx_r   <= {rx_r[14:0], miso};
				end else begin
					sclk_r <= 1'b0;
					cnt_r  <= cnt_r - 6'd1;
					sh_r   <= {sh_r[38:0], 1'b0};
					mosi_r <= sh_r[38];
					if (cnt_r == 6'd1) begin
						busy_r <= 1'b0;
						cs_n_r <= 1'b1;
						done_r <= 1'b1;
						mosi_r <= 1'b0;
					end
				end
			end else begin
				div_r <= div_r + 6'd1;
			end
		end
	end

endmodule // srom_shift

// >>> srom_ctrl.v
// Serial configuration memory access control with an AHB-Lite register port.
// Assumes a single AHB-Lite master, word transfers, and a serial memory on the pins.
`timescale 1ns/1ns
`include "srom_defs.vh"

// Summary of operation
// - Go bit runs one access with opcode
// - Opcode 010 writes data, 011 reads data
// - Opcode 001 writes status, 101 reads it
// - Opcode 110 write enable, 100 write disable
// - Preload done reads one only on success
// - Preload disable bit, resets to one
// - Serial clock divides core clock by 64, by 2 at rate code 3
// - Bit 8 shows memory write busy
// - Bit 9 shows write enable latch
// - Bits 10 and 11 hold block protection
// - Bit 15 holds status write protect enable
// - Companion register low half holds address
// - Companion register high half holds data
module srom_ctrl #(
	parameter [15:0] PL_ADDR = 16'h0000,
	parameter [15:0] PL_SIG  = 16'h5a5a
) (
	// Clock and reset.
	input  wire        hclk,
	input  wire        hresetn,
	// AHB-Lite slave.
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	// Interrupt.
	output wire        irq,
	// Serial memory pins.
	output wire        srom_sclk,
	output wire        srom_cs_n,
	output wire        srom_mosi,
	input  wire        srom_miso
);

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_RUN  = 2'h1;
	localparam [1:0] ST_PL   = 2'h2;

	// Byte offsets and word indices of the mapped registers.
	localparam [11:0] OFS_CTRL  = `SROM_CTRL_OFS;
	localparam [11:0] OFS_ADDR  = `SROM_ADDR_OFS;
	localparam [11:0] OFS_ISTAT = `SROM_ISTAT_OFS;
	localparam [11:0] OFS_IMASK = `SROM_IMASK_OFS;
	localparam [9:0]  IDX_CTRL  = OFS_CTRL[11:2];
	localparam [9:0]  IDX_ADDR  = OFS_ADDR[11:2];
	localparam [9:0]  IDX_ISTAT = OFS_ISTAT[11:2];
	localparam [9:0]  IDX_IMASK = OFS_IMASK[11:2];

	// Bus data phase state.
	reg        dp_wr_r;
	reg        dp_rd_r;
	reg        rd_done_r;
	reg [9:0]  dp_idx_r;

	// Control, companion and interrupt register fields.
	reg        go_r;
	reg [2:0]  op_r;
	reg        pldone_r;
	reg        pldis_r;
	reg [1:0]  rate_r;
	reg [7:0]  stat_r;
	reg [15:0] addr_r;
	reg [15:0] data_r;
	reg [1:0]  ist_r;
	reg [1:0]  imask_r;

	// Sequencer.
	reg [1:0]  state_r;
	reg        pl_tried_r;

	// Miso synchroniser.
	reg        miso_s1_r;
	reg        miso_s2_r;
	reg        miso_s3_r;
	reg        miso_q_r;

	// Serial engine request.
	reg  [39:0] tx;
	reg  [5:0]  nbits;
	reg  [5:0]  half;
	reg  [2:0]  op_sel;
	wire        eng_busy;
	wire        eng_done;
	wire [15:0] eng_rx;
	wire        start;
	wire        sw_launch;
	wire        pl_launch;
	wire        sw_noop;

	// Bus decode.
	wire        accept;
	wire        wr_ctrl;
	wire        wr_addr;
	wire        wr_istat;
	wire        wr_imask;
	wire [1:0]  ist_set;
	wire [1:0]  ist_clr;

	// The bus takes a transfer only when selected, non-idle and ready.
	assign accept = hsel & htrans[1] & hready;

	// Reads take one wait state so the data word comes from a flip-flop.
	assign hreadyout = ~(dp_rd_r & ~rd_done_r);
	assign hresp     = 1'b0;

	// Address phase capture and data phase sequencing.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_r   <= 1'b0;
			dp_rd_r   <= 1'b0;
			rd_done_r <= 1'b0;
			dp_idx_r  <= 10'h000;
		end else begin
			if (hreadyout) begin
				dp_wr_r   <= accept & hwrite;
				dp_rd_r   <= accept & ~hwrite;
				rd_done_r <= 1'b0;
				if (accept) begin
					dp_idx_r <= haddr[11:2];
				end
			end else begin
				rd_done_r <= 1'b1;
			end
		end
	end

	// Write strobes for each mapped word; unmapped writes fall away.
	assign wr_ctrl  = dp_wr_r & (dp_idx_r == IDX_CTRL);
	assign wr_addr  = dp_wr_r & (dp_idx_r == IDX_ADDR);
	assign wr_istat = dp_wr_r & (dp_idx_r == IDX_ISTAT);
	assign wr_imask = dp_wr_r & (dp_idx_r == IDX_IMASK);

	// Read data is loaded in the wait cycle; unmapped words read as zero.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (dp_rd_r & ~rd_done_r) begin
			case (dp_idx_r)
				IDX_CTRL: begin
					hrdata <= {16'h0000, stat_r, rate_r, pldis_r, pldone_r, op_r, go_r};
				end
				IDX_ADDR: begin
					hrdata <= {data_r, addr_r};
				end
				IDX_ISTAT: begin
					hrdata <= {30'h00000000, ist_r};
				end
				IDX_IMASK: begin
					hrdata <= {30'h00000000, imask_r};
				end
				default: begin
					hrdata <= 32'h00000000;
				end
			endcase
		end
	end

	// Three-stage input filter: the level moves once stages two and three agree.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			miso_s1_r <= 1'b0;
			miso_s2_r <= 1'b0;
			miso_s3_r <= 1'b0;
			miso_q_r  <= 1'b0;
		end else begin
			miso_s1_r <= srom_miso;
			miso_s2_r <= miso_s1_r;
			miso_s3_r <= miso_s2_r;
			if (miso_s2_r == miso_s3_r) begin
				miso_q_r <= miso_s3_r;
			end
		end
	end

	// The preload borrows the data read cycle at a fixed address.
	always @* begin
		op_sel = (state_r == ST_PL || pl_launch) ? `SROM_OP_READ : op_r;
	end

	// Build the serial frame for the selected opcode.
	always @* begin
		tx    = 40'h0000000000;
		nbits = 6'h00;
		case (op_sel)
			`SROM_OP_WRSR: begin
				tx    = {`SROM_INS_WRSR, stat_r, 24'h000000};
				nbits = `SROM_BITS_STAT;
			end
			`SROM_OP_WRITE: begin
				tx    = {`SROM_INS_WRITE, addr_r, data_r};
				nbits = `SROM_BITS_DATA;
			end
			`SROM_OP_READ: begin
				tx    = {`SROM_INS_READ, (pl_launch ? PL_ADDR : addr_r), 16'h0000};
				nbits = `SROM_BITS_DATA;
			end
			`SROM_OP_WRDI: begin
				tx    = {`SROM_INS_WRDI, 32'h00000000};
				nbits = `SROM_BITS_SHORT;
			end
			`SROM_OP_RDSR: begin
				tx    = {`SROM_INS_RDSR, 32'h00000000};
				nbits = `SROM_BITS_STAT;
			end
			`SROM_OP_WREN: begin
				tx    = {`SROM_INS_WREN, 32'h00000000};
				nbits = `SROM_BITS_SHORT;
			end
			default: begin
				tx    = 40'h0000000000;
				nbits = 6'h00;
			end
		endcase
	end

	// Half period of the serial clock; reserved codes fall back to divide by 64.
	always @* begin
		if (rate_r == `SROM_RATE_TEST) begin
			half = `SROM_HALF_TEST;
		end else begin
			half = `SROM_HALF_DIV;
		end
	end

	// Software wins over the preload when both are pending.
	assign sw_launch = (state_r == ST_IDLE) & go_r & (nbits != 6'h00);
	assign sw_noop   = (state_r == ST_IDLE) & go_r & (op_r != `SROM_OP_READ) & (nbits == 6'h00);
	assign pl_launch = (state_r == ST_IDLE) & ~go_r & ~pldis_r & ~pl_tried_r;
	// The engine is never asked to start while it still shifts a frame.
	assign start     = (sw_launch | pl_launch) & ~eng_busy;

	// Sequencer and the control and companion fields that the end of an access updates.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r    <= ST_IDLE;
			go_r       <= 1'b0;
			op_r       <= `SROM_OP_NONE;
			pldone_r   <= 1'b0;
			pldis_r    <= `SROM_PLDIS_RST;
			rate_r     <= `SROM_RATE_RST;
			stat_r     <= 8'h00;
			addr_r     <= 16'h0000;
			data_r     <= 16'h0000;
			pl_tried_r <= 1'b0;
		end else begin
			// Software writes to the control word.
			if (wr_ctrl) begin
				pldis_r <= hwdata[`SROM_PLDIS_BIT];
				rate_r  <= hwdata[`SROM_RATE_HI:`SROM_RATE_LO];
				stat_r[2] <= hwdata[10];
				stat_r[3] <= hwdata[11];
				stat_r[7] <= hwdata[15];
				if (!go_r && state_r == ST_IDLE) begin
					op_r <= hwdata[`SROM_OP_HI:`SROM_OP_LO];
					go_r <= hwdata[`SROM_GO_BIT];
				end
			end
			// Address and data halves of the companion word.
			if (wr_addr) begin
				addr_r <= hwdata[15:0];
				data_r <= hwdata[31:16];
			end
			case (state_r)
				ST_IDLE: begin
					if (sw_launch) begin
						state_r <= ST_RUN;
					end else if (sw_noop) begin
						go_r <= 1'b0;
					end else if (pl_launch) begin
						state_r    <= ST_PL;
						pl_tried_r <= 1'b1;
					end
				end
				ST_RUN: begin
					if (eng_done) begin
						state_r <= ST_IDLE;
						go_r    <= 1'b0;
						if (op_r == `SROM_OP_READ) begin
							data_r <= eng_rx;
						end
						if (op_r == `SROM_OP_RDSR) begin
							stat_r <= eng_rx[7:0];
						end
					end
				end
				ST_PL: begin
					if (eng_done) begin
						state_r  <= ST_IDLE;
						pldone_r <= (eng_rx == PL_SIG);
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	// Event sources: software access finished, preload attempt finished.
	assign ist_set[`SROM_IRQ_DONE]    = (state_r == ST_RUN & eng_done) | sw_noop;
	assign ist_set[`SROM_IRQ_PRELOAD] = (state_r == ST_PL) & eng_done;
	assign ist_clr = wr_istat ? hwdata[1:0] : 2'h0;

	// Sticky status cleared by writing one; a new event beats the clear.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ist_r   <= 2'h0;
			imask_r <= 2'h0;
		end else begin
			ist_r <= (ist_r & ~ist_clr) | ist_set;
			if (wr_imask) begin
				imask_r <= hwdata[1:0];
			end
		end
	end

	// Level interrupt while any enabled status bit stands.
	assign irq = |(ist_r & imask_r);

	// Serial engine driving the memory pins.
	srom_shift u_shift (
		.hclk    (hclk),
		.hresetn (hresetn),
		.start   (start),
		.nbits   (nbits),
		.tx      (tx),
		.half    (half),
		.busy_r  (eng_busy),
		.done_r  (eng_done),
		.rx_r    (eng_rx),
		.miso    (miso_q_r),
		.sclk_r  (srom_sclk),
		.cs_n_r  (srom_cs_n),
		.mosi_r  (srom_mosi)
	);

endmodule // srom_ctrl

// >>> srom_ctrl_monitor.sv
// Checker for the serial memory access block, watching its top ports only.
// Assumes hready is tied to hreadyout and the bind sits in the bench file.
`timescale 1ns/1ns
module srom_ctrl_monitor (
	// Clock and reset.
	input wire       hclk,
	input wire       hresetn,
	// Bus.
	input wire       hsel,
	input wire [1:0] htrans,
	input wire       hwrite,
	input wire       hready,
	input wire       hreadyout,
	input wire       hresp,
	// Memory pins.
	input wire       srom_sclk,
	input wire       srom_cs_n,
	input wire       srom_mosi
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	int lo_n;
	int hold_n;
	logic sclk_q;
	logic cs_q;
	// Count frame length and cycles since the serial clock last moved.
	// The gap count restarts while the frame is closed, so a first edge is timed from its start.
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			lo_n <= 0;
			hold_n <= 0;
			sclk_q <= 1'b0;
			cs_q <= 1'b1;
		end else begin
			lo_n <= srom_cs_n ? 0 : lo_n + 1;
			hold_n <= (cs_q || srom_sclk != sclk_q) ? 0 : hold_n + 1;
			sclk_q <= srom_sclk;
			cs_q <= srom_cs_n;
		end
	end
	sequence s_rd_req;
		hsel && htrans[1] && hready && !hwrite;
	endsequence
	sequence s_rd_ans;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_rd_wait;
		s_rd_req |=> s_rd_ans;
	endproperty
	a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
	property p_wr_fast;
		hsel && htrans[1] && hready && hwrite |=> hreadyout;
	endproperty
	a_wr_fast: assert property (p_wr_fast) else $error("write stalled");
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("error response");
	property p_idle_clk;
		srom_cs_n |-> !srom_sclk;
	endproperty
	a_idle_clk: assert property (p_idle_clk) else $error("clock outside frame");
	property p_half;
		(srom_sclk != sclk_q) |-> hold_n == 31 || hold_n == 0;
	endproperty
	a_half: assert property (p_half) else $error("serial half period wrong");
	property p_len;
		$rose(srom_cs_n) |-> lo_n inside {16, 32, 80, 512, 1024, 2560};
	endproperty
	a_len: assert property (p_len) else $error("frame length wrong");
	property p_mosi_fall;
		!srom_cs_n && $past(!srom_cs_n) && $changed(srom_mosi) |-> $fell(srom_sclk);
	endproperty
	a_mosi_fall: assert property (p_mosi_fall) else $error("data moved off fall");
	property p_mosi_idle;
		srom_cs_n && $past(srom_cs_n) |-> !srom_mosi;
	endproperty
	a_mosi_idle: assert property (p_mosi_idle) else $error("data not idle");
endmodule // srom_ctrl_monitor

// >>> srom_mem_model.sv
// Serial configuration memory model: mode 0, MSB first, write latch gating.
// Assumes sclk idles low and moves only while cs_n is low.
`timescale 1ns/1ns
module srom_mem_model (
	// Clock for the released-line pattern.
	input  wire  hclk,
	// Memory pins.
	input  wire  sclk,
	input  wire  cs_n,
	input  wire  mosi,
	output logic miso
);
	logic [39:0] si = 40'h0;
	int          cnt = 0;
	logic [15:0] so = 16'h0;
	logic        wel = 1'b0;
	logic        wip = 1'b0;
	logic [2:0]  prot = 3'h0;
	bit   [15:0] mem [bit [15:0]];
	initial miso = 1'b0;
	// Restart the bit count at each frame.
	always @(negedge cs_n) cnt = 0;
	// Take one bit on each rising edge.
	always @(posedge sclk) begin
		si = {si[38:0], mosi};
		cnt = cnt + 1;
	end
	// Answer on the falling edge after the opcode or the address.
	always @(negedge sclk) begin
		if (cnt == 8 && si[7:0] == 8'h05) so = {prot[2], 3'h0, prot[1:0], wel, wip, 8'h0};
		else if (cnt == 24 && si[23:16] == 8'h03) so = mem[si[15:0]];
		else so = so << 1;
		miso = so[15];
	end
	// Carry out latch, status and data commands when the frame closes.
	always @(posedge cs_n) begin
		if (cnt == 8 && si[7:0] == 8'h06) wel = 1'b1;
		if (cnt == 8 && si[7:0] == 8'h04) wel = 1'b0;
		// A finished data write reports busy to the next status read, whose frame close then clears it.
		if (cnt == 16 && si[15:8] == 8'h05) wip = 1'b0;
		if (cnt == 16 && si[15:8] == 8'h01 && wel) begin
			prot = {si[7], si[3:2]};
			wel = 1'b0;
		end
		if (cnt == 40 && si[39:32] == 8'h02 && wel) begin
			mem[si[31:16]] = si[15:0];
			wel = 1'b0;
			wip = 1'b1;
		end
	end
	// A released line keeps toggling so no stale level can be read.
	always @(posedge hclk) if (cs_n) miso <= ~miso;
endmodule // srom_mem_model

// >>> serial_rom_access_control_bench.sv
// Self-checking bench for the serial memory access block over AHB-Lite.
// Assumes the memory model and checker files are compiled first.
`timescale 1ns/1ns
module serial_rom_access_control_bench;
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] rd;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, irq, sclk, cs_n, mosi, miso;
	int          n_mismatch = 0;
	int          cmp_count = 0;
	// Free-running bus clock.
	always #5 hclk = ~hclk;
	srom_ctrl uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.irq(irq), .srom_sclk(sclk), .srom_cs_n(cs_n), .srom_mosi(mosi),
		.srom_miso(miso));
	srom_mem_model mem (.hclk(hclk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));
	task report_and_stop;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task lost;
		n_mismatch++;
		$display("[ERR] t=%0t wait expired got %h exp %h", $time, 32'h0, 32'h1);
		report_and_stop;
	endtask
	// Wait for hready high at a rising edge, catching read data with it.
	task wait_rdy;
		int i;
		i = 0;
		do begin
			@(negedge hclk);
			i++;
		end while (hreadyout !== 1'b1 && i < 99);
		if (hreadyout !== 1'b1) lost;
		rd = hrdata;
		@(posedge hclk);
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy;
	endtask
	// Start one access, poll until go clears, then check and clear the interrupt.
	task run_op(input logic [31:0] base, input logic [2:0] op);
		int i;
		bus(1'b1, 32'ha0, base | {op, 1'b1});
		i = 0;
		do begin
			bus(1'b0, 32'ha0, 32'h0);
			i++;
		end while (rd[0] !== 1'b0 && i < 2000);
		if (rd[0] !== 1'b0) lost;
		@(negedge hclk);
		chk({31'h0, irq}, 32'h1);
		@(posedge hclk);
		bus(1'b1, 32'hc0, 32'h1);
		@(negedge hclk);
		chk({31'h0, irq}, 32'h0);
		@(posedge hclk);
	endtask
	task t_regs;
		bus(1'b0, 32'ha0, 32'h0);
		chk(rd, 32'h60);
		bus(1'b0, 32'ha4, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, 32'ha0, 32'h7370);
		bus(1'b0, 32'ha0, 32'h0);
		chk(rd, 32'h60);
		bus(1'b1, 32'ha8, 32'hffffffff);
		bus(1'b0, 32'ha8, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, 32'hc4, 32'h1);
		$display("test regs done");
	endtask
	task t_latch;
		run_op(32'h60, 3'h6);
		run_op(32'h60, 3'h5);
		chk(rd, 32'h26a);
		run_op(32'ha0, 3'h4);
		run_op(32'h60, 3'h5);
		chk(rd, 32'h6a);
		$display("test latch done");
	endtask
	task t_data;
		run_op(32'h20, 3'h6);
		bus(1'b1, 32'ha4, 32'h5a5a0000);
		run_op(32'h60, 3'h2);
		run_op(32'h60, 3'h5);
		chk(rd, 32'h16a);
		run_op(32'h60, 3'h5);
		chk(rd, 32'h6a);
		bus(1'b1, 32'ha4, 32'h0);
		run_op(32'h60, 3'h3);
		bus(1'b0, 32'ha4, 32'h0);
		chk(rd, 32'h5a5a0000);
		$display("test data done");
	endtask
	task t_stat;
		run_op(32'h60, 3'h6);
		run_op(32'h8c60, 3'h1);
		run_op(32'h60, 3'h5);
		chk(rd, 32'h8c6a);
		run_op(32'h60, 3'h0);
		run_op(32'h60, 3'h7);
		run_op(32'he0, 3'h6);
		$display("test status done");
	endtask
	task t_pre;
		int i;
		bus(1'b1, 32'ha0, 32'h40);
		i = 0;
		do begin
			bus(1'b0, 32'hc0, 32'h0);
			i++;
		end while (rd[1] !== 1'b1 && i < 2000);
		if (rd[1] !== 1'b1) lost;
		bus(1'b0, 32'ha0, 32'h0);
		chk(rd, 32'h50);
		$display("test preload done");
	endtask
	// Reset, then run every scenario in turn.
	initial begin
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs;
		t_latch;
		t_data;
		t_stat;
		t_pre;
		report_and_stop;
	end
endmodule // serial_rom_access_control_bench
bind srom_ctrl srom_ctrl_monitor mon (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
	.hreadyout, .hresp, .srom_sclk, .srom_cs_n, .srom_mosi);
